// ==== design/isee_mem.sv ====
// Byte array with a one-page write buffer and a combinational read port.
// Assumes the caller clears the buffer after each commit or abandon.
`timescale 1ns/1ns
`default_nettype none
module isee_mem
  import isee_pkg::*;
#(
  parameter int DEPTH = ISEE_MEM_BYTES,
  parameter int PAGE = ISEE_PAGE_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic buf_load,
  input wire logic [ISEE_OFS_W-1:0] buf_ofs,
  input wire logic [ISEE_BYTE_W-1:0] buf_byte,
  input wire logic buf_clear,
  input wire logic commit,
  input wire logic [ISEE_PAGE_W-1:0] commit_page,
  input wire logic [ISEE_ADDR_W-1:0] rd_addr,
  output logic [ISEE_BYTE_W-1:0] rd_byte
);

  logic [ISEE_BYTE_W-1:0] mem [DEPTH];
  logic [ISEE_BYTE_W-1:0] pbuf [PAGE];
  logic [PAGE-1:0] pvld_r;

  // Array content is nonvolatile, so reset leaves it alone
  genvar g;
  generate
    for (g = 0; g < PAGE; g++) begin : g_ent
      always_ff @(posedge clk_sys) begin
        if (buf_load && buf_ofs == ISEE_OFS_W'(g)) begin
          pbuf[g] <= buf_byte;
        end
      end
    end
  endgenerate

  // One process owns the array; only buffered offsets are written
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      for (int i = 0; i < PAGE; i++) begin
        if (pvld_r[i]) begin
          mem[{commit_page, ISEE_OFS_W'(i)}] <= pbuf[i];
        end
      end
    end
  end

  // Later bytes to one offset simply replace earlier ones
  always_ff @(posedge clk_sys) begin
    if (!rst_n || buf_clear) begin
      pvld_r <= '0;
    end else if (buf_load) begin
      pvld_r[buf_ofs] <= 1'b1;
    end
  end

  assign rd_byte = mem[rd_addr];

endmodule
`default_nettype wire

// ==== design/isee_sync.sv ====
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module isee_sync #(
  parameter int W = 6,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } isee_sync_t;

  isee_sync_t r, n;

  always_comb begin
    n = r;
    n.s1 = async_in;
    n.s2 = r.s1;
  end

  // Resets to each pin's idle level, so no false edge follows reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      r <= '{s1: RST_VAL, s2: RST_VAL};
    end else begin
      r <= n;
    end
  end

  assign sync_out = r.s2;

endmodule
`default_nettype wire

// ==== design/isee_top.sv ====
// What this block does
// R1: Reset puts the slave in standby
// R2: Sample on SCL rise, launch on fall
// R3: Three straps set the select code
// R4: Write protect high blocks all writes
// R5: Drive low for zero, release for one
// R6: Master starts only on idle bus
// R7: SDA change with SCL high is event
// R8: START is SDA fall, SCL high
// R9: STOP programs after write, else standby
// R10: Address byte: class, select, direction
// R11: Acknowledge address, word address, write data
// R12: Release SDA in read ninth clock
// R13: Byte write acknowledges three bytes
// R14: No address acknowledge while programming
// R15: 128 bytes, sixteen-byte pages
// R16: Write counter wraps inside page
// R17: Immediate read starts at held counter
// R18: Dummy write loads counter for selective read
// R19: Keep sending while master acknowledges
// R20: Read counter wraps over whole array
// R21: Programming is timed busy interval
//
// Serial memory slave top: pins in, open-drain data out.
// Assumes scl_i/sda_i are the resolved wire levels, pulled up off chip.
`timescale 1ns/1ns
`default_nettype none
module isee_top
  import isee_pkg::*;
#(
  // Arbitrary class prefix, not a real part code
  parameter logic [3:0] CLASS_PREFIX = 4'h6,
  parameter int WR_CYCLES = ISEE_WR_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic write_protect_i,
  output logic write_busy
);

  isee_regs_t r, n;

  logic [5:0] pins_sync;
  logic scl;
  logic sda;
  logic [ISEE_STRAP_W-1:0] straps;
  logic wp;

  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;

  logic buf_load;
  logic buf_clear;
  logic commit;
  logic [ISEE_BYTE_W-1:0] rd_byte;

  // Every pin crosses into clk_sys before use
  // Bus pins idle high, straps and protect idle low
  isee_sync #(
    .W(6),
    .RST_VAL(6'h03)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .async_in({write_protect_i, select_strap_bit2, select_strap_bit1,
               select_strap_bit0, sda_i, scl_i}),
    .sync_out(pins_sync)
  );

  assign scl = pins_sync[0];
  assign sda = pins_sync[1];
  assign straps = pins_sync[4:2]; // [R3]
  assign wp = pins_sync[5];

  // Edges seen against the last sampled levels
  assign scl_rise = scl && !r.scl_d;
  assign scl_fall = !scl && r.scl_d;
  assign start_ev = scl && r.scl_d && r.sda_d && !sda; // [R7] [R8]
  assign stop_ev = scl && r.scl_d && !r.sda_d && sda; // [R7] [R9]

  isee_mem u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .buf_load(buf_load),
    .buf_ofs(r.addr[ISEE_OFS_W-1:0]),
    .buf_byte(r.shreg),
    .buf_clear(buf_clear),
    .commit(commit),
    .commit_page(r.addr[ISEE_ADDR_W-1:ISEE_OFS_W]),
    .rd_addr(r.addr),
    .rd_byte(rd_byte)
  );

  function automatic logic addr_match(input logic [ISEE_BYTE_W-1:0] b,
                                      input logic [ISEE_STRAP_W-1:0] s);
    addr_match = (b[ISEE_BYTE_W-1:ISEE_CLASS_LSB] == CLASS_PREFIX) &&
                 (b[ISEE_CLASS_LSB-1:ISEE_SEL_LSB] == s);
  endfunction

  // Every field named, so a new field cannot slip past reset
  function automatic isee_regs_t reset_regs();
    isee_regs_t v;
    v = '0;
    v.st = ISEE_IDLE;
    v.scl_d = 1'b1;
    v.sda_d = 1'b1;
    v.bitcnt = '0;
    v.shreg = '0;
    v.addr = ISEE_ADDR_RST;
    v.ack_ph = 1'b0;
    v.rw = 1'b0;
    v.mack = 1'b0;
    v.wr_pend = 1'b0;
    v.busy_cnt = '0;
    v.busy = 1'b0;
    v.sda_out = ISEE_SDA_OUT_RST;
    v.sda_oe = ISEE_OE_RST;
    reset_regs = v;
  endfunction

  // Load a byte for sending; bit 7 goes out with the load
  function automatic isee_regs_t launch_byte(input isee_regs_t s,
                                             input logic [ISEE_BYTE_W-1:0] b);
    isee_regs_t v;
    v = s;
    v.st = ISEE_RDATA;
    v.bitcnt = '0;
    v.shreg = b;
    v.sda_oe = !b[ISEE_BYTE_W-1]; // [R2] [R5]
    // Counter moves on as the byte leaves, over the whole array
    v.addr = s.addr + 7'h01; // [R20]
    launch_byte = v;
  endfunction

  always_comb begin
    n = r;
    buf_load = 1'b0;
    buf_clear = 1'b0;
    commit = 1'b0;

    n.scl_d = scl;
    n.sda_d = sda;

    // Programming timer runs down on its own
    if (r.busy_cnt != '0) begin
      n.busy_cnt = r.busy_cnt - ISEE_BUSY_W'(1);
    end

    if (stop_ev) begin
      n.st = ISEE_IDLE;
      n.sda_oe = 1'b0;
      n.ack_ph = 1'b0;
      n.bitcnt = '0;
      if (r.wr_pend) begin
        // Protected writes still spend the busy time, but store nothing
        commit = !wp; // [R4] [R21]
        n.busy_cnt = ISEE_BUSY_W'(WR_CYCLES); // [R9] [R21]
        buf_clear = 1'b1;
        n.wr_pend = 1'b0;
      end
    end else if (start_ev) begin
      // A repeated start abandons bytes not yet committed
      n.st = ISEE_DEV; // [R8]
      n.sda_oe = 1'b0;
      n.ack_ph = 1'b0;
      n.bitcnt = '0;
      if (r.wr_pend) begin
        buf_clear = 1'b1;
        n.wr_pend = 1'b0;
      end
    end else begin
      unique case (r.st)
        ISEE_IDLE: begin
          // Bus is ignored until a start is seen
          n.sda_oe = 1'b0; // [R8]
        end

        ISEE_DEV, ISEE_WORD, ISEE_WDATA: begin
          if (scl_rise && !r.ack_ph) begin
            n.shreg = {r.shreg[ISEE_BYTE_W-2:0], sda}; // [R2]
            n.bitcnt = r.bitcnt + 4'h1;
          end else if (scl_fall && r.ack_ph) begin
            // Ninth clock over: let go and move on
            n.ack_ph = 1'b0;
            n.sda_oe = 1'b0;
            n.bitcnt = '0;
            unique case (r.st)
              ISEE_DEV: begin
                if (r.rw) begin
                  n = launch_byte(n, rd_byte); // [R17]
                end else begin
                  n.st = ISEE_WORD;
                end
              end
              ISEE_WORD: n.st = ISEE_WDATA;
              ISEE_WDATA: n.st = ISEE_WDATA;
              ISEE_IDLE, ISEE_RDATA, ISEE_RACK: n.st = ISEE_IDLE;
            endcase
          end else if (scl_fall && r.bitcnt == ISEE_BYTE_DONE) begin
            unique case (r.st)
              ISEE_DEV: begin
                if (addr_match(r.shreg, straps) && !r.busy) begin // [R10] [R14]
                  n.rw = r.shreg[ISEE_DIR_BIT];
                  n.ack_ph = 1'b1;
                  n.sda_oe = 1'b1; // [R11]
                end else begin
                  n.st = ISEE_IDLE;
                  n.bitcnt = '0;
                end
              end
              ISEE_WORD: begin
                // Top address bit is beyond the array and dropped
                n.addr = r.shreg[ISEE_ADDR_W-1:0]; // [R15] [R18]
                n.ack_ph = 1'b1;
                n.sda_oe = 1'b1; // [R11]
              end
              ISEE_WDATA: begin
                buf_load = 1'b1; // [R13]
                n.wr_pend = 1'b1;
                n.addr = {r.addr[ISEE_ADDR_W-1:ISEE_OFS_W],
                          r.addr[ISEE_OFS_W-1:0] + 4'h1}; // [R16]
                n.ack_ph = 1'b1;
                n.sda_oe = 1'b1; // [R11] [R13]
              end
              ISEE_IDLE, ISEE_RDATA, ISEE_RACK: n.st = ISEE_IDLE;
            endcase
          end
        end

        ISEE_RDATA: begin
          if (scl_fall) begin
            if (r.bitcnt != ISEE_LAST_TX) begin
              n.bitcnt = r.bitcnt + 4'h1;
              n.shreg = {r.shreg[ISEE_BYTE_W-2:0], 1'b0};
              n.sda_oe = !r.shreg[ISEE_BYTE_W-2]; // [R2] [R5]
            end else begin
              n.sda_oe = 1'b0; // [R12]
              n.st = ISEE_RACK;
            end
          end
        end

        ISEE_RACK: begin
          if (scl_rise) begin
            n.mack = !sda; // [R2]
          end else if (scl_fall) begin
            if (r.mack) begin
              n = launch_byte(n, rd_byte); // [R19]
            end else begin
              // Master withheld its acknowledge: go idle until the next start
              n.st = ISEE_IDLE; // [R12]
            end
          end
        end
      endcase
    end

    n.busy = (n.busy_cnt != '0); // [R14] [R21]
    n.sda_out = ISEE_SDA_OUT_RST; // [R5]
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // Power-on and brown-out both land here
      r <= reset_regs(); // [R1]
    end else begin
      r <= n;
    end
  end

  assign sda_o = r.sda_out;
  assign sda_oe = r.sda_oe;
  assign write_busy = r.busy;

endmodule
`default_nettype wire

// ==== dv/isee_master.sv ====
// Two-wire bus master model: makes the clock, pulls data low.
// Assumes the bench resolves a pulled-up data wire.
`timescale 1ns/1ns
`default_nettype none
module isee_master (
  input wire logic clk_sys,
  input wire logic sda,
  output var logic scl,
  output var logic pull_low
);
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
  end
  task automatic q();
    repeat (5) @(posedge clk_sys);
  endtask
  // Data moves mid clock-low only
  task automatic bit_io(input logic b, output logic r);
    pull_low <= !b;
    q();
    scl <= 1'b1;
    q();
    r = sda;
    q();
    scl <= 1'b0;
    q();
  endtask
  task automatic start();
    pull_low <= 1'b0;
    q();
    scl <= 1'b1;
    q();
    pull_low <= 1'b1;
    q();
    scl <= 1'b0;
    q();
  endtask
  // Clock left high: it stands still between frames
  task automatic stop();
    pull_low <= 1'b1;
    q();
    scl <= 1'b1;
    q();
    pull_low <= 1'b0;
    q();
    q();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(!mack, r);
  endtask
endmodule
`default_nettype wire

// ==== dv/isee_props.sv ====
// Pin-level checks for the serial memory slave.
// Assumes binding onto isee_top; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module isee_props #(
  parameter int WR_CYCLES = 400
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  input wire logic select_strap_bit0,
  input wire logic select_strap_bit1,
  input wire logic select_strap_bit2,
  input wire logic write_protect_i,
  input wire logic write_busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Busy length counted here; too long for a repetition
  logic [19:0] bcnt_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !write_busy) bcnt_r <= 20'h00000;
    else bcnt_r <= bcnt_r + 20'h00001;
  end
  chk_drive_low: assert property (sda_o == 1'b0) else $error("data out not low");
  chk_oe_edge: assert property ($changed(sda_oe) |-> !scl_i && $past(scl_i, 7))
    else $error("drive moved off clock low");
  chk_busy_len: assert property ($fell(write_busy) |-> bcnt_r == 20'(WR_CYCLES))
    else $error("busy length wrong");
  chk_busy_stop: assert property ($rose(write_busy) |-> scl_i && sda_i && !$past(sda_i, 8))
    else $error("busy not from stop");
  chk_busy_quiet: assert property (write_busy |-> !sda_oe) else $error("drive while busy");
  chk_ack_hold: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("drive too short");
  chk_oe_release: assert property ($rose(sda_oe) |-> ##[1:200] !sda_oe)
    else $error("drive never released");
  chk_rst_idle: assert property ($rose(rst_n) |-> !sda_oe && !write_busy)
    else $error("not idle after reset");
  cover property ($rose(write_busy));
  cover property ($fell(write_busy));
  cover property ($rose(sda_oe) && !write_busy);
endmodule
bind isee_top isee_props #(.WR_CYCLES(WR_CYCLES)) chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .select_strap_bit0(select_strap_bit0), .select_strap_bit1(select_strap_bit1),
  .select_strap_bit2(select_strap_bit2), .write_protect_i(write_protect_i),
  .write_busy(write_busy));
`default_nettype wire

// ==== dv/tb_top.sv ====
// Bench for the serial memory slave against a master model.
// Assumes the package, design and dv files compile first.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam logic [3:0] CLS = 4'h6;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] strap = 3'h0;
  logic wp = 1'b0;
  logic scl, pull_low, sda_o, sda_oe, write_busy, a;
  logic [7:0] d;
  logic [7:0] exp_mem [128];
  int failures = 0;
  int n_compared = 0;
  wire sda_w = !(sda_oe && !sda_o) && !pull_low;
  initial begin
    forever #4 clk_sys = !clk_sys;
  end
  // Short busy so polling still lands inside it
  isee_top #(.CLASS_PREFIX(CLS), .WR_CYCLES(400)) uut (.clk_sys(clk_sys), .rst_n(rst_n),
    .scl_i(scl),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .select_strap_bit0(strap[0]),
    .select_strap_bit1(strap[1]), .select_strap_bit2(strap[2]),
    .write_protect_i(wp), .write_busy(write_busy));
  isee_master m (.clk_sys(clk_sys), .sda(sda_w), .scl(scl), .pull_low(pull_low));
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      failures++;
    end
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 1000 && write_busy !== 1'b0; i++)
      @(posedge clk_sys);
    if (i == 1000) begin
      failures++;
      summarize();
    end
  endtask
  task automatic dev(input logic dir);
    m.start();
    m.wbyte({CLS, strap, dir}, a);
  endtask
  task automatic sel(input logic [7:0] at);
    dev(1'b0);
    chk(8'(a), 8'h01);
    m.wbyte(at, a);
    chk(8'(a), 8'h01);
  endtask
  task automatic wr1(input logic [7:0] at, input logic [7:0] v);
    sel(at);
    m.wbyte(v, a);
    chk(8'(a), 8'h01);
    m.stop();
    chk(8'(write_busy), 8'h01);
    wait_idle();
  endtask
  task automatic rd(input int n, input int at);
    dev(1'b1);
    chk(8'(a), 8'h01);
    for (int k = 0; k < n; k++) begin
      m.rbyte(k < n - 1, d);
      chk(d, exp_mem[(at + k) % 128]);
    end
    m.stop();
  endtask
  task automatic t_strap();
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      @(posedge clk_sys);
      dev(1'b0);
      chk(8'(a), 8'h01);
      m.stop();
      m.start();
      m.wbyte({CLS, 3'(s ^ 1), 1'b1}, a);
      chk(8'(a), 8'h00);
      m.wbyte({CLS, strap, 1'b0}, a);
      chk(8'(a), 8'h00);
      m.stop();
    end
    m.start();
    m.wbyte({~CLS, strap, 1'b0}, a);
    chk(8'(a), 8'h00);
    m.stop();
  endtask
  task automatic t_page();
    sel(8'h2E);
    for (int k = 0; k < 17; k++) begin
      m.wbyte(8'h40 + 8'(k), a);
      chk(8'(a), 8'h01);
      exp_mem[32 + ((14 + k) % 16)] = 8'h40 + 8'(k);
    end
    m.stop();
    dev(1'b0);
    chk(8'(a), 8'h00);
    m.stop();
    wait_idle();
    sel(8'h20);
    rd(15, 32);
    rd(1, 47);
  endtask
  task automatic t_wrap();
    wr1(8'h7F, 8'hA5);
    wr1(8'h00, 8'h5A);
    exp_mem[127] = 8'hA5;
    exp_mem[0] = 8'h5A;
    sel(8'h7F);
    rd(2, 127);
  endtask
  task automatic t_wp();
    wp <= 1'b1;
    wr1(8'h7F, 8'h33);
    wp <= 1'b0;
    sel(8'h7F);
    rd(1, 127);
  endtask
  // Counter parked off zero, then a mid-run reset must bring it back
  task automatic t_reset();
    sel(8'h20);
    m.stop();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(8'({sda_oe, write_busy}), 8'h00);
    repeat (4) @(posedge clk_sys);
    rd(1, 0);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_strap();
    t_page();
    t_wrap();
    t_wp();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire

// ==== include/isee_pkg.sv ====
// Constants and types shared by the serial memory slave.
// Assumes a single 125 MHz system clock and a synchronous active-low reset.
package isee_pkg;

  localparam int ISEE_BYTE_W = 8;
  localparam int ISEE_ADDR_W = 7;
  localparam int ISEE_OFS_W = 4;
  localparam int ISEE_PAGE_W = 3;
  localparam int ISEE_MEM_BYTES = 128;
  localparam int ISEE_PAGE_BYTES = 16;
  localparam int ISEE_STRAP_W = 3;

  // Field positions of the address byte
  localparam int ISEE_DIR_BIT = 0;
  localparam int ISEE_SEL_LSB = 1;
  localparam int ISEE_CLASS_LSB = 4;

  // Bit counter marks
  localparam logic [3:0] ISEE_BYTE_DONE = 4'h8;
  localparam logic [3:0] ISEE_LAST_TX = 4'h7;

  // Programming time
  localparam int ISEE_CLK_MHZ = 125;
  localparam int ISEE_T_WR_US = 5000;
  localparam int ISEE_WR_CYC = ISEE_T_WR_US * ISEE_CLK_MHZ;
  localparam int ISEE_BUSY_W = 20;

  // Reset values
  localparam logic ISEE_SDA_OUT_RST = 1'b0;
  localparam logic ISEE_OE_RST = 1'b0;
  localparam logic [ISEE_ADDR_W-1:0] ISEE_ADDR_RST = 7'h00;

  typedef enum logic [2:0] {
    ISEE_IDLE,
    ISEE_DEV,
    ISEE_WORD,
    ISEE_WDATA,
    ISEE_RDATA,
    ISEE_RACK
  } isee_state_t;

  typedef struct packed {
    isee_state_t st;
    logic scl_d;
    logic sda_d;
    logic [3:0] bitcnt;
    logic [ISEE_BYTE_W-1:0] shreg;
    logic [ISEE_ADDR_W-1:0] addr;
    logic ack_ph;
    logic rw;
    logic mack;
    logic wr_pend;
    logic [ISEE_BUSY_W-1:0] busy_cnt;
    logic busy;
    logic sda_out;
    logic sda_oe;
  } isee_regs_t;

endpackage
